// [inc/smr_params.svh]
// constants for the smbus slave register port
`ifndef SMR_PARAMS_SVH
`define SMR_PARAMS_SVH
`define SMR_ADDR_DEFAULT   7'h2E
`define SMR_ADDR_STRAP_LO  7'h2C
`define SMR_ADDR_STRAP_HI  7'h2D
`define SMR_ADDR_ALERT     7'h0C
`define SMR_ADDR_GENCALL   7'h00
`define SMR_MATCH_BITS     5
`define SMR_UNMAPPED_DATA  8'h00
`define SMR_CLK_MHZ        125
`define SMR_TIMEOUT_US     25000
`define SMR_TIMEOUT_CYC    ((`SMR_TIMEOUT_US * `SMR_CLK_MHZ))
`define SMR_GLITCH_CYC     4
`endif

// [inc/smr_pkg.sv]
// types for the smbus slave register port
package smr_pkg;
   typedef enum logic [7:0] {
      SMR_IDLE  = 8'b0000_0001,
      SMR_ADDR  = 8'b0000_0010,
      SMR_INDEX = 8'b0000_0100,
      SMR_DATA  = 8'b0000_1000,
      SMR_RADDR = 8'b0001_0000,
      SMR_SEND  = 8'b0010_0000,
      SMR_ACK   = 8'b0100_0000,
      SMR_WAIT  = 8'b1000_0000
   } smr_state_t;
endpackage

// [src/smr_filter.sv]
// synchroniser and glitch filter for one bus line
`timescale 1ns/1ps
module smr_filter #(
   parameter int GLITCH_CYC = 4
) (
   // clock and control
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic clk_en,
   // line
   input  wire logic line_in,
   output logic      line_out
);
   // two stage synchroniser, first stage read only by second
   logic        sync_a;
   logic        sync_b;
   logic [3:0]  cnt;    // stable run length

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else if (clk_en) begin
         sync_a <= line_in;
         sync_b <= sync_a;
      end
   end

   // accept a new level only after it stands GLITCH_CYC cycles
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt      <= 4'h0;
         line_out <= 1'b1;
      end else if (clk_en) begin
         if (sync_b == line_out) begin
            cnt <= 4'h0;
         end else if (cnt == 4'(GLITCH_CYC - 1)) begin
            cnt      <= 4'h0;
            line_out <= sync_b;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule // smr_filter

// [src/smr_timeout.sv]
// clock-low timeout counter
`timescale 1ns/1ps
module smr_timeout #(
   parameter int TIMEOUT_CYC = 3125000
) (
   // clock and control
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic clk_en,
   // observed clock level and activity
   input  wire logic scl_low,
   input  wire logic active,
   // abort pulse
   output logic      expired
);
   logic [31:0] cnt;   // cycles of clock low

   // count low time inside a transfer, fire once at the limit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt     <= 32'h0000_0000;
         expired <= 1'b0;
      end else if (clk_en) begin
         expired <= 1'b0;
         if (!scl_low || !active) begin
            cnt <= 32'h0000_0000;
         end else if (cnt == 32'(TIMEOUT_CYC - 1)) begin
            cnt     <= 32'h0000_0000;
            expired <= 1'b1;
         end else begin
            cnt <= cnt + 32'h0000_0001;
         end
      end
   end
endmodule // smr_timeout

// [src/smr_slave.sv]
// smbus slave front end: byte protocols into register accesses
`include "smr_params.svh"
`timescale 1ns/1ps
// What this block does
// R1: enable strap high gives default address
// R2: enable strap low selects address by select strap
// R3: strap address locks on first write acknowledged at own address
// R4: slave only; write byte and read byte
// R5: seven-bit address, eight-bit index and data
// R6: every byte shifted msb first
// R7: write: address, index, data all acknowledged
// R8: read: repeated start, one byte, host nacks
// R9: repeated start marks a read
// R10: register written only after complete write
// R11: bad address or format: no ack, idle
// R12: alert address acknowledged only when alert pending
// R13: unassigned index reads zero, writes ignored; here reg_wr pulses for any index
// R14: general call never acknowledged
// R15: clock low past limit aborts transfer
// R16: never drives the bus clock
// R17: start then stop resets to idle
// R18: alert needs enable and an event bit
// R19: alert reply carries own address on top
// R20: alert acknowledge clears the alert enable
// R21: bus inputs synchronised and filtered
// R22: straps sampled once at reset
module smr_slave #(
   parameter int TIMEOUT_CYC = `SMR_TIMEOUT_CYC,
   parameter int GLITCH_CYC  = `SMR_GLITCH_CYC
) (
   // clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // address straps
   input  wire logic       addr_enable_n,
   input  wire logic       fan_speed_input_four,
   // bus pins, data open drain, oe low while driving
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   output logic            scl_out,
   output logic            scl_oe_n,
   // register side
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_index,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_mapped,
   // alert side
   input  wire logic       alert_interrupt_enable,
   input  wire logic       alert_event,
   output logic            alert_enable_clear,
   // status
   output logic [6:0]      own_addr,
   output logic            addr_locked
);
   // ***************************************
   // input conditioning
   // ***************************************
   logic scl_f;          // filtered clock
   logic sda_f;          // filtered data
   logic scl_d;          // previous clock
   logic sda_d;          // previous data
   logic strap_a;        // strap sync stage one
   logic strap_b;        // strap sync stage two
   logic sel_a;          // select sync stage one
   logic sel_b;          // select sync stage two

   smr_filter #(.GLITCH_CYC(GLITCH_CYC)) u_fscl (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .line_in  (scl_in),
      .line_out (scl_f)
   ); // R21
   smr_filter #(.GLITCH_CYC(GLITCH_CYC)) u_fsda (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .line_in  (sda_in),
      .line_out (sda_f)
   ); // R21

   // previous filtered levels for edge finding
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (clk_en) begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   wire scl_rise = scl_f & ~scl_d;
   wire scl_fall = ~scl_f & scl_d;
   wire start_c  = scl_f & scl_d & sda_d & ~sda_f;
   wire stop_c   = scl_f & scl_d & ~sda_d & sda_f;

   // ***************************************
   // strap capture and address lock
   // ***************************************
   logic       strap_taken;  // straps caught after reset
   logic       strap_mode;   // strap addressing in use
   logic       strap_sel;    // caught select level

   // synchronise straps; pins come from outside
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strap_a <= 1'b1;
         strap_b <= 1'b1;
         sel_a   <= 1'b0;
         sel_b   <= 1'b0;
      end else if (clk_en) begin
         strap_a <= addr_enable_n;
         strap_b <= strap_a;
         sel_a   <= fan_speed_input_four;
         sel_b   <= sel_a;
      end
   end

   // catch straps once after release; held until next reset
   logic [1:0] strap_wait;   // lets the synchroniser fill
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         strap_wait  <= 2'h0;
         strap_taken <= 1'b0;
         strap_mode  <= 1'b0;
         strap_sel   <= 1'b0;
      end else if (clk_en && !strap_taken) begin
         if (strap_wait == 2'h3) begin
            strap_taken <= 1'b1;            // R22
            strap_mode  <= ~strap_b;        // R1 R2
            strap_sel   <= sel_b;
         end else begin
            strap_wait <= strap_wait + 2'h1;
         end
      end
   end

   // address choice; strap levels only matter until caught after reset
   logic [6:0] live_addr;
   logic [6:0] locked_addr;
   always_comb begin
      if (!strap_mode) begin
         live_addr = `SMR_ADDR_DEFAULT;     // R1
      end else if (strap_sel) begin
         live_addr = `SMR_ADDR_STRAP_HI;    // R2
      end else begin
         live_addr = `SMR_ADDR_STRAP_LO;    // R2
      end
   end
   assign own_addr = addr_locked ? locked_addr : live_addr;

   // ***************************************
   // byte engine
   // ***************************************
   smr_pkg::smr_state_t state;
   smr_pkg::smr_state_t ret_state;   // where to go after ack
   logic [7:0]  shreg;       // shift register
   logic [3:0]  bitcnt;      // bits seen in this byte
   logic        is_alert;    // transfer aimed at alert address
   logic        got_index;   // index byte taken in this transfer
   logic        got_data;    // data byte waiting for stop
   logic        drive_low;   // pull data line low
   logic        just_start;  // start seen, no bit since
   logic        to_abort;    // timeout pulse
   logic [7:0]  tx;          // byte being returned

   smr_timeout #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_to (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clk_en  (clk_en),
      .scl_low (~scl_f),
      .active  (state != smr_pkg::SMR_IDLE),
      .expired (to_abort)
   ); // R15

   // address byte checks
   wire [6:0] rx_addr   = shreg[7:1];                                       // R5
   wire       hit_five  = rx_addr[6:2] == own_addr[6:2];                       // R3
   wire       hit_own   = rx_addr == own_addr;
   wire       alert_ok  = alert_interrupt_enable & alert_event;                 // R18
   wire       hit_alert = (rx_addr == `SMR_ADDR_ALERT) & shreg[0] & alert_ok;   // R12

   // main sequencer: edges of the filtered clock drive it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state              <= smr_pkg::SMR_IDLE;
         ret_state          <= smr_pkg::SMR_IDLE;
         shreg              <= 8'h00;
         bitcnt             <= 4'h0;
         is_alert           <= 1'b0;
         got_index          <= 1'b0;
         got_data           <= 1'b0;
         drive_low          <= 1'b0;
         just_start         <= 1'b0;
         tx                 <= 8'h00;
         reg_index          <= 8'h00;
         reg_wdata          <= 8'h00;
         reg_wr             <= 1'b0;
         reg_rd             <= 1'b0;
         alert_enable_clear <= 1'b0;
         addr_locked        <= 1'b0;
         locked_addr        <= 7'h00;
      end else if (clk_en) begin
         reg_wr             <= 1'b0;
         reg_rd             <= 1'b0;
         alert_enable_clear <= 1'b0;
         if (to_abort) begin
            state     <= smr_pkg::SMR_IDLE;  // R15
            drive_low <= 1'b0;
            got_data  <= 1'b0;
         end else if (stop_c) begin
            // write completes only on stop after a full data byte
            if (got_data && !just_start) begin
               reg_wr <= 1'b1;               // R10 R13
            end
            state      <= smr_pkg::SMR_IDLE; // R17
            drive_low  <= 1'b0;
            got_data   <= 1'b0;
            just_start <= 1'b0;
         end else if (start_c) begin
            // repeated start after index marks a read
            state      <= got_index && state != smr_pkg::SMR_IDLE
                          ? smr_pkg::SMR_RADDR : smr_pkg::SMR_ADDR;  // R9
            bitcnt     <= 4'h0;
            drive_low  <= 1'b0;
            got_data   <= 1'b0;
            just_start <= 1'b1;
            if (state == smr_pkg::SMR_IDLE) begin
               got_index <= 1'b0;
            end
         end else begin
            case (state)
               smr_pkg::SMR_IDLE: begin
                  got_index <= 1'b0;
               end
               smr_pkg::SMR_ADDR, smr_pkg::SMR_INDEX,
               smr_pkg::SMR_DATA, smr_pkg::SMR_RADDR: begin
                  if (scl_rise) begin
                     shreg      <= {shreg[6:0], sda_f};   // R6
                     bitcnt     <= bitcnt + 4'h1;
                     just_start <= 1'b0;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     case (state)
                        smr_pkg::SMR_ADDR: begin
                           // write bit to own address, or read bit to alert address when pending; others idle
                           if (!shreg[0] && hit_own
                               && rx_addr != `SMR_ADDR_GENCALL) begin   // R14
                              drive_low <= 1'b1;           // R7
                              ret_state <= smr_pkg::SMR_INDEX;
                              state     <= smr_pkg::SMR_ACK;
                              is_alert  <= 1'b0;
                              if (strap_mode && !addr_locked && hit_five) begin
                                 addr_locked <= 1'b1;      // R3
                                 locked_addr <= live_addr;
                              end
                           end else if (hit_alert) begin
                              drive_low          <= 1'b1;  // R12
                              alert_enable_clear <= 1'b1;  // R20
                              tx                 <= {own_addr, 1'b1};   // R19
                              is_alert           <= 1'b1;
                              ret_state          <= smr_pkg::SMR_SEND;
                              state              <= smr_pkg::SMR_ACK;
                           end else begin
                              state <= smr_pkg::SMR_IDLE;  // R4 R11
                           end
                        end
                        smr_pkg::SMR_INDEX: begin
                           reg_index <= shreg;
                           got_index <= 1'b1;
                           drive_low <= 1'b1;              // R7
                           ret_state <= smr_pkg::SMR_DATA;
                           state     <= smr_pkg::SMR_ACK;
                        end
                        smr_pkg::SMR_DATA: begin
                           reg_wdata <= shreg;
                           got_data  <= 1'b1;
                           drive_low <= 1'b1;              // R7
                           ret_state <= smr_pkg::SMR_WAIT;
                           state     <= smr_pkg::SMR_ACK;
                        end
                        smr_pkg::SMR_RADDR: begin
                           if (hit_own && shreg[0]) begin
                              drive_low <= 1'b1;           // R8
                              reg_rd    <= 1'b1;
                              ret_state <= smr_pkg::SMR_SEND;
                              state     <= smr_pkg::SMR_ACK;
                              is_alert  <= 1'b0;
                           end else begin
                              state <= smr_pkg::SMR_IDLE;  // R11
                           end
                        end
                        default: begin
                           state <= smr_pkg::SMR_IDLE;
                        end
                     endcase
                  end
               end
               smr_pkg::SMR_ACK: begin
                  // ack bit spans one clock pulse; on its fall release, or drive the first bit of a read
                  if (scl_fall) begin
                     state  <= ret_state;
                     bitcnt <= 4'h0;
                     if (ret_state == smr_pkg::SMR_SEND) begin
                        if (!is_alert) begin
                           tx <= reg_mapped ? reg_rdata : `SMR_UNMAPPED_DATA;   // R13
                        end
                        drive_low <= ~(is_alert ? tx[7] : (reg_mapped & reg_rdata[7]));   // R6
                        bitcnt    <= 4'h1;
                     end else begin
                        drive_low <= 1'b0;
                     end
                  end
               end
               smr_pkg::SMR_SEND: begin
                  // shift out msb first; ninth bit is host nack
                  if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        drive_low <= 1'b0;
                        state     <= smr_pkg::SMR_WAIT;    // R8
                     end else begin
                        drive_low <= ~tx[3'(7 - bitcnt)];
                        bitcnt    <= bitcnt + 4'h1;
                     end
                  end
               end
               smr_pkg::SMR_WAIT: begin
                  // start or stop leaves, and after a write an extra clock; a stop also raises the clock,
                  // so only a completed extra clock pulse marks a bad format
                  if (scl_fall && got_data) begin
                     got_data <= 1'b0;                     // R10
                     state    <= smr_pkg::SMR_IDLE;
                  end
               end
               default: begin
                  state <= smr_pkg::SMR_IDLE;
               end
            endcase
         end
      end
   end

   // ***************************************
   // pins
   // ***************************************
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~drive_low;
   // the clock pin is never pulled; other agents may stretch it
   assign scl_out  = 1'b0;
   assign scl_oe_n = 1'b1;     // R16
endmodule // smr_slave

// [testbench/smr_slave_monitor.sv]
// pin-level checker for the smbus slave register port
`include "smr_params.svh"
`timescale 1ns/1ps
module smr_slave_monitor #(
   parameter int TIMEOUT_CYC = 3125000
) (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // bus pins
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_oe_n,
   input wire logic       scl_oe_n,
   // register and alert side
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       alert_interrupt_enable,
   input wire logic       alert_event,
   input wire logic       alert_enable_clear,
   // status
   input wire logic [6:0] own_addr,
   input wire logic       addr_locked
);
   // ********************
   // helper logic
   // ********************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   int low_cyc; // pin clock-low length, saturates so it never wraps
   always_ff @(posedge clk_sys) begin
      if (rst || scl_in) begin
         low_cyc <= 0;
      end else if (low_cyc < TIMEOUT_CYC + 64) begin
         low_cyc <= low_cyc + 1;
      end
   end
   // ********************
   // checks
   // ********************
   property p_clk_free; scl_oe_n; endproperty
   a_clk_free: assert property (p_clk_free) else $error("bus clock driven");
   property p_wr_once; reg_wr |=> !reg_wr; endproperty
   a_wr_once: assert property (p_wr_once) else $error("write pulse too long");
   property p_wr_at_stop; reg_wr |-> scl_in && sda_in && sda_oe_n; endproperty
   a_wr_at_stop: assert property (p_wr_at_stop) else $error("write outside idle bus");
   property p_rd_alone; reg_rd |-> !reg_wr ##1 !reg_rd; endproperty
   a_rd_alone: assert property (p_rd_alone) else $error("read pulse malformed");
   property p_alert_cause; alert_enable_clear |-> $past(alert_interrupt_enable) && $past(alert_event); endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert clear without pending alert");
   property p_clear_once; alert_enable_clear |=> !alert_enable_clear [*4]; endproperty
   a_clear_once: assert property (p_clear_once) else $error("alert clear repeated");
   property p_lock_keep; addr_locked |=> addr_locked && $stable(own_addr); endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("locked address moved");
   property p_lock_strap; addr_locked |-> own_addr inside {`SMR_ADDR_STRAP_LO, `SMR_ADDR_STRAP_HI}; endproperty
   a_lock_strap: assert property (p_lock_strap) else $error("locked address not a strap value");
   property p_sda_on_low; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_sda_on_low: assert property (p_sda_on_low) else $error("data moved while clock high");
   property p_timeout; low_cyc > TIMEOUT_CYC + 16 |-> sda_oe_n; endproperty
   a_timeout: assert property (p_timeout) else $error("data held past clock-low limit");
endmodule // smr_slave_monitor

// [testbench/smr_host_model.sv]
// host bus controller model: drives the bus clock, pulls data low
`timescale 1ns/1ps
module smr_host_model #(
   parameter int PH = 33 // quarter bit in ns, off the system clock grid
) (
   // bus clock and data pull-down, low while pulling
   output logic      scl_drv,
   output logic      sda_drv_n,
   // resolved data line
   input  wire logic sda_bus
);
   // idle: both lines left to the pull-ups
   initial begin
      scl_drv = 1'b1;
      sda_drv_n = 1'b1;
   end
   // one bit: data set mid-low, sampled mid-high, clock left low
   task automatic bit_io(input logic b, output logic r);
      #PH;
      sda_drv_n = b;
      #PH;
      scl_drv = 1'b1;
      #PH;
      r = sda_bus;
      #PH;
      scl_drv = 1'b0;
   endtask
   // start (1,0) or stop (0,1); long lead lets the slave drop its ack first
   task automatic cond(input logic a, input logic b);
      #(2*PH);
      sda_drv_n = a;
      #PH;
      scl_drv = 1'b1;
      #PH;
      sda_drv_n = b;
      #PH;
      scl_drv = b;
   endtask
   // send a byte msb first, then read the acknowledge
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // take a byte msb first, then answer; a read ends with nack
   task automatic rx(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask
endmodule // smr_host_model

// [testbench/tb_smr_slave.sv]
// self-checking bench for the smbus slave register port
`include "smr_params.svh"
`timescale 1ns/1ps
module tb_smr_slave;
   // ********************
   // signals
   // ********************
   localparam int TO_CYC = 200; // short clock-low limit keeps the run brief
   logic       clk_sys, rst, clk_en, addr_enable_n, fan_speed_input_four;
   logic       alert_interrupt_enable, alert_event, sda_out, sda_oe_n, scl_out, scl_oe_n;
   logic       reg_wr, reg_rd, alert_enable_clear, addr_locked, reg_mapped, scl_drv, sda_drv_n;
   logic [7:0] reg_index, reg_wdata, reg_rdata, wr_idx, wr_dat, rd_val, ti, td;
   logic [6:0] own_addr, me;
   logic [2:0] ak;
   wire logic  scl_bus, sda_bus;
   int         error_cnt = 0, check_count = 0, wr_cnt = 0, clr_cnt = 0, cyc = 0, n;
   // open-drain lines with pull-ups
   assign scl_bus = scl_drv & (scl_oe_n | scl_out);
   assign sda_bus = sda_drv_n & (sda_oe_n | sda_out);
   // register file stand-in: upper half of the index space unassigned
   assign reg_rdata = reg_index ^ 8'hA5;
   assign reg_mapped = ~reg_index[7];
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   smr_slave #(.TIMEOUT_CYC(TO_CYC)) uut (.clk_sys, .rst, .clk_en, .addr_enable_n, .fan_speed_input_four,
      .scl_in(scl_bus), .sda_in(sda_bus), .sda_out, .sda_oe_n, .scl_out, .scl_oe_n, .reg_wr, .reg_rd,
      .reg_index, .reg_wdata, .reg_rdata, .reg_mapped, .alert_interrupt_enable, .alert_event,
      .alert_enable_clear, .own_addr, .addr_locked);
   smr_host_model host (.scl_drv, .sda_drv_n, .sda_bus);
   // observer of write and alert-clear pulses, plus the run limit
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (reg_wr) begin
         wr_cnt <= wr_cnt + 1;
         wr_idx <= reg_index;
         wr_dat <= reg_wdata;
      end
      if (alert_enable_clear) begin
         clr_cnt <= clr_cnt + 1;
      end
      if (cyc == 60000) begin
         error_cnt++;
         close_out();
      end
   end
   // ********************
   // tasks
   // ********************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // unassigned indexes read as zero
   function automatic logic [7:0] exp_rd(input logic [7:0] i);
      return i[7] ? 8'h00 : i ^ 8'hA5;
   endfunction
   // straps are set while reset is held
   task automatic do_reset(input logic en_n, input logic sel);
      @(posedge clk_sys);
      rst <= 1'b1;
      addr_enable_n <= en_n;
      fan_speed_input_four <= sel;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (16) @(posedge clk_sys);
   endtask
   // write byte transfer; ak holds address, index and data acks
   task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
      n = wr_cnt;
      host.cond(1'b1, 1'b0);
      host.tx({a, 1'b0}, ak[2]);
      host.tx(i, ak[1]);
      host.tx(d, ak[0]);
      host.cond(1'b0, 1'b1);
      repeat (12) @(posedge clk_sys);
   endtask
   // read byte transfer; ak holds both address acks and the index ack
   task automatic rd(input logic [6:0] a, input logic [7:0] i);
      host.cond(1'b1, 1'b0);
      host.tx({a, 1'b0}, ak[2]);
      host.tx(i, ak[1]);
      host.cond(1'b1, 1'b0);
      host.tx({a, 1'b1}, ak[0]);
      host.rx(1'b1, rd_val);
      host.cond(1'b0, 1'b1);
   endtask
   // ********************
   // sequence
   // ********************
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      addr_enable_n = 1'b0;
      fan_speed_input_four = 1'b0;
      alert_interrupt_enable = 1'b0;
      alert_event = 1'b0;
      n = $urandom(32'h1314);
      me = n[0] ? `SMR_ADDR_STRAP_HI : `SMR_ADDR_STRAP_LO;
      do_reset(1'b0, n[0]);
      check(16'(own_addr), 16'(me));
      check(16'(addr_locked), 16'h0000);
      fan_speed_input_four <= ~fan_speed_input_four;
      for (int k = 0; k < 6; k++) begin
         ti = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : 8'($urandom);
         td = 8'($urandom);
         wr(me, ti, td);
         check(16'(ak), 16'h0007);
         check(16'(wr_cnt - n), 16'h0001);
         check({wr_idx, wr_dat}, {ti, td});
         rd(me, ti);
         check(16'(ak), 16'h0007);
         check(16'(rd_val), 16'(exp_rd(ti)));
      end
      check(16'(addr_locked), 16'h0001);
      check(16'(own_addr), 16'(me));
      $display("strap and transfer test done");
      for (int k = 0; k < 3; k++) begin
         wr((k == 0) ? me ^ 7'h01 : (k == 1) ? `SMR_ADDR_GENCALL : 7'h3E, 8'h10, 8'h55);
         check(16'(ak), 16'h0000);
         check(16'(wr_cnt - n), 16'h0000);
      end
      $display("refusal test done");
      n = wr_cnt;
      host.cond(1'b1, 1'b0);
      host.tx({me, 1'b0}, ak[2]);
      host.tx(8'h11, ak[1]);
      host.cond(1'b0, 1'b1);
      host.cond(1'b1, 1'b0);
      host.cond(1'b0, 1'b1);
      host.cond(1'b1, 1'b0);
      host.tx({me, 1'b1}, ak[0]);
      host.cond(1'b0, 1'b1);
      repeat (12) @(posedge clk_sys);
      check(16'(wr_cnt - n), 16'h0000);
      check(16'(ak[0]), 16'h0000);
      wr(me, 8'h22, 8'h33);
      check(16'(ak), 16'h0007);
      $display("malformed test done");
      for (int k = 1; k < 4; k++) begin
         @(posedge clk_sys);
         alert_interrupt_enable <= k[1];
         alert_event <= k[0];
         n = clr_cnt;
         repeat (2) @(posedge clk_sys);
         host.cond(1'b1, 1'b0);
         host.tx({`SMR_ADDR_ALERT, 1'b1}, ak[0]);
         host.rx(1'b1, rd_val);
         host.cond(1'b0, 1'b1);
         repeat (4) @(posedge clk_sys);
         check(16'(ak[0]), 16'(k == 3));
         check(16'(clr_cnt - n), 16'(k == 3));
      end
      check(16'(rd_val[7:1]), 16'(me));
      $display("alert test done");
      rd(me, 8'h90);
      host.cond(1'b1, 1'b0);
      host.tx({me, 1'b0}, ak[2]);
      host.tx(8'h90, ak[1]);
      host.cond(1'b1, 1'b0);
      host.tx({me, 1'b1}, ak[0]);
      repeat (100) @(negedge clk_sys);
      check(16'(sda_bus), 16'h0000);
      repeat (200) @(negedge clk_sys);
      check(16'(sda_bus), 16'h0001);
      host.cond(1'b0, 1'b1);
      wr(me, 8'h44, 8'h66);
      check(16'(ak), 16'h0007);
      $display("timeout test done");
      do_reset(1'b1, 1'b0);
      check(16'(own_addr), 16'(`SMR_ADDR_DEFAULT));
      wr(`SMR_ADDR_DEFAULT, 8'h05, 8'hC3);
      check(16'(ak), 16'h0007);
      check(16'(addr_locked), 16'h0000);
      $display("default address test done");
      close_out();
   end
endmodule // tb_smr_slave
bind smr_slave smr_slave_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.clk_sys, .rst, .scl_in, .sda_in,
   .sda_oe_n, .scl_oe_n, .reg_wr, .reg_rd, .alert_interrupt_enable, .alert_event, .alert_enable_clear,
   .own_addr, .addr_locked);
